// [common/cic_regs.vh]
/*
 * register map, bit positions and reset values of the core interrupt control block.
 * assumes a wishbone slave with byte-index addressing: byte address = 4 * index.
 */
`ifndef CIC_REGS_VH
`define CIC_REGS_VH

// register indices; byte address is four times the index
`define CIC_IDX_PFLAG1      10'h011
`define CIC_IDX_PFLAG2      10'h012
`define CIC_IDX_PFLAG3      10'h013
`define CIC_IDX_PEN1        10'h091
`define CIC_IDX_PEN2        10'h092
`define CIC_IDX_PEN3        10'h093
`define CIC_IDX_PA_RISE     10'h391
`define CIC_IDX_PA_FALL     10'h392
`define CIC_IDX_PA_CHG      10'h393
`define CIC_IDX_PC_RISE     10'h397
`define CIC_IDX_PC_FALL     10'h398
`define CIC_IDX_PC_CHG      10'h399
`define CIC_IDX_INTCTL      10'h00b

// interrupt control bit positions
`define CIC_BIT_GLB_EN      7
`define CIC_BIT_PGATE       6
`define CIC_BIT_T0EN        5
`define CIC_BIT_EXTEN       4
`define CIC_BIT_CHGEN       3
`define CIC_BIT_T0FLG       2
`define CIC_BIT_EXTFLG      1
`define CIC_BIT_CHGFLG      0

// reset values
`define CIC_RST_INTCTL      8'h00
`define CIC_RST_BYTE        8'h00

`endif

// [rtl/cic_edge_det.v]
/*
 * per-pin change detector: three-flop sampling of external pins, rise/fall
 * selection and sticky change flags with software clear (set wins).
 * assumes pins are asynchronous to mclk_i.
 */
`timescale 1ns/1ps
module cic_edge_det #(
    parameter W = 8
) (
    // clock and reset
    input  wire         mclk_i,
    input  wire         rst_n_i,
    // pins and selections
    input  wire [W-1:0] pin_i,
    input  wire [W-1:0] rise_en_i,
    input  wire [W-1:0] fall_en_i,
    // software write of the flag register
    input  wire         wr_i,
    input  wire [W-1:0] wdata_i,
    // flags
    output wire [W-1:0] flags_o
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    reg [W-1:0] lvl_q;
    reg [W-1:0] flg_q;
    reg [W-1:0] flg_d;
    wire [W-1:0] agree;
    wire [W-1:0] rise;
    wire [W-1:0] fall;

    // a change counts only once second and third stage agree
    assign agree = ~(s2_q ^ s3_q);
    assign rise  = agree & s3_q & ~lvl_q;
    assign fall  = agree & ~s3_q & lvl_q;

    // software may only clear bits; a new edge in that cycle wins
    always @* begin
        flg_d = flg_q;
        if (wr_i) begin
            flg_d = flg_q & wdata_i;
        end
        flg_d = flg_d | (rise & rise_en_i) | (fall & fall_en_i);
    end

    // synchroniser, filtered level and flags
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q  <= {W{1'b0}};
            s2_q  <= {W{1'b0}};
            s3_q  <= {W{1'b0}};
            lvl_q <= {W{1'b0}};
            flg_q <= {W{1'b0}};
        end else begin
            s1_q  <= pin_i;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= (agree & s3_q) | (~agree & lvl_q);
            flg_q <= flg_d;
        end
    end

    assign flags_o = flg_q;
endmodule

// [rtl/cic_sync_pulse.v]
/*
 * synchronises an asynchronous event pin and turns its active edge into a
 * one-cycle pulse. assumes the pin is asynchronous to mclk_i.
 */
`timescale 1ns/1ps
module cic_sync_pulse (
    // clock and reset
    input  wire mclk_i,
    input  wire rst_n_i,
    // pin and edge choice (1 = rising)
    input  wire pin_i,
    input  wire rising_i,
    // event
    output wire pulse_o
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg lvl_q;
    wire agree;

    assign agree = ~(s2_q ^ s3_q);
    // pulse when the filtered level moves in the chosen direction
    assign pulse_o = agree && (s3_q != lvl_q) && (s3_q == rising_i);

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q  <= pin_i;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            if (agree) begin
                lvl_q <= s3_q;
            end
        end
    end
endmodule

// [rtl/cic_core_irq.v]
/*
 * core interrupt control: interrupt control register, peripheral flag and
 * enable banks, pin-change detect registers, and the combined request.
 * assumes a classic wishbone master on mclk_i, peripherals giving one-cycle
 * set pulses, and external pins asynchronous to the clock.
 */
// Design decision made here: the Wishbone slave port.
// Functional notes
// - global enable bit 7 gates every interrupt
// - peripheral gate bit 6 gates peripheral sources
// - bit 5 enables timer0 overflow interrupt
// - bit 4 enables external pin interrupt
// - bit 3 enables pin-change summary interrupt
// - bit 2 set on timer0 overflow
// - bit 1 set on external pin event
// - bit 0 shows any recorded pin change
// - summary flag read-only, clears with per-port flags
// - flags set regardless of enables
// - interrupt control resets to zero always
`timescale 1ns/1ps
`include "cic_regs.vh"
module cic_core_irq #(
    parameter NPA = 6,
    parameter NPC = 8
) (
    // clock and reset
    input  wire          mclk_i,
    input  wire          rst_n_i,
    // wishbone slave
    input  wire          wb_cyc_i,
    input  wire          wb_stb_i,
    input  wire          wb_we_i,
    input  wire [11:0]   wb_adr_i,
    input  wire [3:0]    wb_sel_i,
    input  wire [31:0]   wb_dat_i,
    output reg  [31:0]   wb_dat_o,
    output reg           wb_ack_o,
    // event sources
    input  wire          timer0_overflow_i,
    input  wire          ext_pin_i,
    input  wire          ext_pin_rising_i,
    input  wire [NPA-1:0] port_a_pin_i,
    input  wire [NPC-1:0] port_c_pin_i,
    input  wire [23:0]   periph_set_i,
    // request to the core
    output reg           irq_o
);
    reg  [7:0] intctl_q;
    reg  [7:0] pflag_q [0:2];
    reg  [7:0] pen_q [0:2];
    reg  [NPA-1:0] pa_rise_q;
    reg  [NPA-1:0] pa_fall_q;
    reg  [NPC-1:0] pc_rise_q;
    reg  [NPC-1:0] pc_fall_q;
    reg  [7:0] intctl_d;
    reg  [7:0] rdata;
    reg        hit;
    wire [NPA-1:0] pa_flags;
    wire [NPC-1:0] pc_flags;
    wire       ext_evt;
    wire       chg_any;
    wire       req;
    wire       wr_stb;
    wire [9:0] idx;
    wire [7:0] wbyte;
    integer    i;

    // byte address is four times the register index
    assign idx    = wb_adr_i[11:2];
    assign wbyte  = wb_dat_i[7:0];
    assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

    // true when a write lands on the given index
    function wr_hit;
        input [9:0] want;
        begin
            wr_hit = wr_stb && (idx == want);
        end
    endfunction

    // pin-change detectors for both ports
    cic_edge_det #(.W(NPA)) u_pa (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (port_a_pin_i),
        .rise_en_i (pa_rise_q),
        .fall_en_i (pa_fall_q),
        .wr_i      (wr_hit(`CIC_IDX_PA_CHG)),
        .wdata_i   (wbyte[NPA-1:0]),
        .flags_o   (pa_flags)
    );

    cic_edge_det #(.W(NPC)) u_pc (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (port_c_pin_i),
        .rise_en_i (pc_rise_q),
        .fall_en_i (pc_fall_q),
        .wr_i      (wr_hit(`CIC_IDX_PC_CHG)),
        .wdata_i   (wbyte[NPC-1:0]),
        .flags_o   (pc_flags)
    );

    // external interrupt pin event
    cic_sync_pulse u_ext (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n_i),
        .pin_i    (ext_pin_i),
        .rising_i (ext_pin_rising_i),
        .pulse_o  (ext_evt)
    );

    // summary follows the per-port flags directly, so it clears only with them
    assign chg_any = (|pa_flags) | (|pc_flags);

    // interrupt control next value: software write, then hardware sets win
    always @* begin
        intctl_d = intctl_q;
        if (wr_hit(`CIC_IDX_INTCTL)) begin
            intctl_d[7:1] = wbyte[7:1];
        end
        if (timer0_overflow_i) begin
            intctl_d[`CIC_BIT_T0FLG] = 1'b1;
        end
        if (ext_evt) begin
            intctl_d[`CIC_BIT_EXTFLG] = 1'b1;
        end
        intctl_d[`CIC_BIT_CHGFLG] = chg_any;
    end

    // combined request; stale flags fire at once if enabled uncleared
    assign req = intctl_q[`CIC_BIT_GLB_EN] && (
                 (intctl_q[`CIC_BIT_T0EN]  && intctl_q[`CIC_BIT_T0FLG])  ||
                 (intctl_q[`CIC_BIT_EXTEN] && intctl_q[`CIC_BIT_EXTFLG]) ||
                 (intctl_q[`CIC_BIT_CHGEN] && intctl_q[`CIC_BIT_CHGFLG]) ||
                 (intctl_q[`CIC_BIT_PGATE] &&
                  (|(pflag_q[0] & pen_q[0]) || |(pflag_q[1] & pen_q[1]) || |(pflag_q[2] & pen_q[2]))));

    // read decode; unmapped addresses read zero but are still acknowledged
    always @* begin
        rdata = 8'h00;
        hit   = 1'b1;
        case (idx)
            `CIC_IDX_INTCTL:  rdata = intctl_q;
            `CIC_IDX_PFLAG1:  rdata = pflag_q[0];
            `CIC_IDX_PFLAG2:  rdata = pflag_q[1];
            `CIC_IDX_PFLAG3:  rdata = pflag_q[2];
            `CIC_IDX_PEN1:    rdata = pen_q[0];
            `CIC_IDX_PEN2:    rdata = pen_q[1];
            `CIC_IDX_PEN3:    rdata = pen_q[2];
            `CIC_IDX_PA_RISE: rdata[NPA-1:0] = pa_rise_q;
            `CIC_IDX_PA_FALL: rdata[NPA-1:0] = pa_fall_q;
            `CIC_IDX_PA_CHG:  rdata[NPA-1:0] = pa_flags;
            `CIC_IDX_PC_RISE: rdata[NPC-1:0] = pc_rise_q;
            `CIC_IDX_PC_FALL: rdata[NPC-1:0] = pc_fall_q;
            `CIC_IDX_PC_CHG:  rdata[NPC-1:0] = pc_flags;
            default:          hit = 1'b0;
        endcase
    end

    // registers, bus answer and request flop
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            intctl_q  <= `CIC_RST_INTCTL;
            pa_rise_q <= {NPA{1'b0}};
            pa_fall_q <= {NPA{1'b0}};
            pc_rise_q <= {NPC{1'b0}};
            pc_fall_q <= {NPC{1'b0}};
            for (i = 0; i < 3; i = i + 1) begin
                pflag_q[i] <= `CIC_RST_BYTE;
                pen_q[i]   <= `CIC_RST_BYTE;
            end
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            irq_o    <= 1'b0;
        end else begin
            intctl_q <= intctl_d;
            irq_o    <= req;
            // one-cycle ack, dropped the cycle after it was given
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= {24'h00_0000, (hit ? rdata : 8'h00)};
            if (wr_hit(`CIC_IDX_PA_RISE)) begin
                pa_rise_q <= wbyte[NPA-1:0];
            end
            if (wr_hit(`CIC_IDX_PA_FALL)) begin
                pa_fall_q <= wbyte[NPA-1:0];
            end
            if (wr_hit(`CIC_IDX_PC_RISE)) begin
                pc_rise_q <= wbyte[NPC-1:0];
            end
            if (wr_hit(`CIC_IDX_PC_FALL)) begin
                pc_fall_q <= wbyte[NPC-1:0];
            end
            for (i = 0; i < 3; i = i + 1) begin
                if (wr_hit(`CIC_IDX_PEN1 + i[9:0])) begin
                    pen_q[i] <= wbyte;
                end
                // peripheral flags: write, then a set in the same cycle wins
                pflag_q[i] <= (wr_hit(`CIC_IDX_PFLAG1 + i[9:0]) ? wbyte : pflag_q[i])
                              | periph_set_i[i*8 +: 8];
            end
        end
    end
endmodule

// [verif/cic_core_irq_checker.sv]
/* checker for cic_core_irq: bus handshake, reset and request gating.
   assumes a classic wishbone master and the control register at byte 0x2c. */
`timescale 1ns/1ps
module cic_core_irq_checker (
    // clock and reset
    input wire        mclk_i,
    input wire        rst_n_i,
    // bus
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // events and request
    input wire        timer0_overflow_i,
    input wire        irq_o
);
    logic [7:3] en_q;
    wire        req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // shadow of the enables, so gating is judged from the pins alone
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            en_q <= 5'h00;
        else if (req & wb_we_i & wb_sel_i[0] & (wb_adr_i == 12'h02c))
            en_q <= wb_dat_i[7:3];
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_t0_armed;
        timer0_overflow_i && en_q[7] && en_q[5] ##1 en_q[7] && en_q[5];
    endsequence
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_answers: assert property (req |=> wb_ack_o)
        else $error("request not acked");
    a_ack_cause: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    a_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_reset_quiet: assert property ($rose(rst_n_i) |-> !irq_o && !wb_ack_o)
        else $error("outputs active after reset");
    a_global_blocks: assert property (!$past(en_q[7]) && !$past(en_q[7], 2) |-> !irq_o)
        else $error("request with global enable clear");
    a_none_enabled: assert property ($past(en_q[6:3]) == 4'h0 && $past(en_q[6:3], 2) == 4'h0 |-> !irq_o)
        else $error("request with no source enabled");
    a_timer_raises: assert property (s_t0_armed |-> ##[0:2] irq_o)
        else $error("timer overflow gave no request");
endmodule
bind cic_core_irq cic_core_irq_checker u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer0_overflow_i(timer0_overflow_i), .irq_o(irq_o));

// [verif/cic_core_model.sv]
/* model of the processor core: counts each request it is offered.
   assumes the request is a level on the core clock. */
`timescale 1ns/1ps
module cic_core_model (
    // clock and reset
    input  wire        mclk_i,
    input  wire        rst_n_i,
    // request and count of entries
    input  wire        irq_i,
    output logic [7:0] n_taken_o
);
    logic seen_q;
    // one entry per rising request, since the core returns only when it drops
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen_q    <= 1'b0;
            n_taken_o <= 8'h00;
        end else begin
            seen_q <= irq_i;
            if (irq_i & ~seen_q)
                n_taken_o <= n_taken_o + 8'h01;
        end
    end
endmodule

// [verif/cic_core_irq_tb.sv]
/* self-checking bench for cic_core_irq with a core model.
   assumes the register map header and registered one-cycle acks. */
`timescale 1ns/1ps
`include "cic_regs.vh"
module cic_core_irq_tb;
    localparam logic [11:0] A_CTL = {`CIC_IDX_INTCTL, 2'b00};
    localparam logic [11:0] A_F1 = {`CIC_IDX_PFLAG1, 2'b00};
    localparam logic [11:0] A_E1 = {`CIC_IDX_PEN1, 2'b00};
    localparam logic [11:0] A_PAR = {`CIC_IDX_PA_RISE, 2'b00};
    localparam logic [11:0] A_PAF = {`CIC_IDX_PA_CHG, 2'b00};
    localparam logic [11:0] A_PCN = {`CIC_IDX_PC_FALL, 2'b00};
    localparam logic [11:0] A_PCC = {`CIC_IDX_PC_CHG, 2'b00};
    logic        mclk_i = 0, rst_n_i = 0, cyc = 0, stb = 0, we = 0, t0 = 0, ext = 0, erise = 1;
    logic [11:0] adr = 0;
    logic [31:0] wdat = 0;
    logic [5:0]  pa = 0;
    logic [7:0]  pc = 0;
    logic [23:0] ps = 0;
    logic [7:0]  q;
    wire  [31:0] rdat;
    wire  [7:0]  n_taken;
    wire         ack, irq;
    integer      n_mismatch = 0, n_tests = 0;
    cic_core_irq dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .timer0_overflow_i(t0), .ext_pin_i(ext), .ext_pin_rising_i(erise), .port_a_pin_i(pa),
        .port_c_pin_i(pc), .periph_set_i(ps), .irq_o(irq));
    cic_core_model core (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .irq_i(irq), .n_taken_o(n_taken));
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one classic cycle; held until ack is sampled high, bounded wait
    task bus(input logic [11:0] a, input logic w, input logic [7:0] d);
        integer i;
        @(posedge mclk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= {24'h0, d};
        for (i = 0; i < 20; i++) begin
            @(posedge mclk_i);
            if (ack === 1'b1) break;
        end
        q = rdat[7:0];
        cyc <= 0; stb <= 0;
        if (i == 20) begin
            n_mismatch++;
            tally_and_finish;
        end
    endtask
    task rd(input logic [11:0] a, input logic [7:0] exp);
        bus(a, 0, 8'h00);
        chk("register", q, exp);
    endtask
    // longer than the slowest pin path, so the request has settled
    task irq_is(input logic e);
        repeat (10) @(posedge mclk_i);
        chk("request", {7'h0, irq}, {7'h0, e});
    endtask
    task pulse_t0;
        @(posedge mclk_i) t0 <= 1;
        @(posedge mclk_i) t0 <= 0;
    endtask
    task t_access;
        rd(A_CTL, 8'h00);
        bus(A_CTL, 1, 8'hf9);
        rd(A_CTL, 8'hf8);
        irq_is(0);
        bus(12'hffc, 1, 8'h5a);
        rd(12'hffc, 8'h00);
        bus(A_CTL, 1, 8'h00);
    endtask
    // a flag left set raises the request once its enables are set; it is not cleared first
    task t_timer;
        pulse_t0;
        rd(A_CTL, 8'h04);
        bus(A_CTL, 1, 8'h24);
        irq_is(0);
        bus(A_CTL, 1, 8'ha4);
        irq_is(1);
        bus(A_CTL, 1, 8'ha0);
        irq_is(0);
        pulse_t0;
        irq_is(1);
        bus(A_CTL, 1, 8'h00);
    endtask
    task t_ext;
        ext <= 1;
        irq_is(0);
        rd(A_CTL, 8'h02);
        bus(A_CTL, 1, 8'h92);
        irq_is(1);
        ext <= 0;
        bus(A_CTL, 1, 8'h00);
        irq_is(0);
        // falling-edge mode: a rise must not count, the fall must
        erise <= 0;
        ext <= 1;
        irq_is(0);
        rd(A_CTL, 8'h00);
        ext <= 0;
        irq_is(0);
        rd(A_CTL, 8'h02);
        bus(A_CTL, 1, 8'h00);
    endtask
    task t_change;
        bus(A_PAR, 1, 8'h01);
        pa <= 6'h01;
        irq_is(0);
        rd(A_CTL, 8'h01);
        bus(A_CTL, 1, 8'h88);
        irq_is(1);
        rd(A_CTL, 8'h89);
        bus(A_PAF, 1, 8'h00);
        irq_is(0);
        rd(A_CTL, 8'h88);
        bus(A_CTL, 1, 8'h00);
        // port c: an unselected rise records nothing, a selected fall does
        pc <= 8'h80;
        irq_is(0);
        rd(A_CTL, 8'h00);
        bus(A_PCN, 1, 8'h80);
        pc <= 8'h00;
        irq_is(0);
        rd(A_PCC, 8'h80);
        rd(A_CTL, 8'h01);
        bus(A_PCC, 1, 8'h00);
        irq_is(0);
        rd(A_CTL, 8'h00);
    endtask
    task t_periph;
        bus(A_E1, 1, 8'h01);
        @(posedge mclk_i) ps <= 24'h000001;
        @(posedge mclk_i) ps <= 24'h000000;
        rd(A_F1, 8'h01);
        bus(A_CTL, 1, 8'h80);
        irq_is(0);
        bus(A_CTL, 1, 8'hc0);
        irq_is(1);
        bus(A_F1, 1, 8'h00);
        irq_is(0);
        chk("entries", n_taken, 8'h05);
        // load enables first, so the reset has something to clear
        bus(A_CTL, 1, 8'h78);
        rd(A_CTL, 8'h78);
        @(posedge mclk_i) rst_n_i <= 0;
        @(posedge mclk_i) rst_n_i <= 1;
        rd(A_CTL, 8'h00);
    endtask
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1;
        t_access;
        t_timer;
        t_ext;
        t_change;
        t_periph;
        tally_and_finish;
    end
endmodule
